// *** bcl_regs.svh ***
// Register offsets, field positions, reset values, opcodes and timing counts of the branch/call/load decoder
`ifndef BCL_REGS_SVH
`define BCL_REGS_SVH

`define BCL_OFF_CTRL 8'h00
`define BCL_OFF_PC 8'h04
`define BCL_OFF_STATUS 8'h08
`define BCL_OFF_TARGET 8'h0C
`define BCL_OFF_OPERAND 8'h10
`define BCL_OFF_RETADDR 8'h14

`define BCL_CTRL_RESET 1'b1
`define BCL_PC_RESET 20'h00000
`define BCL_CTRL_EN_BIT 0
`define BCL_ST_BUSY_BIT 0
`define BCL_ST_BAD_BIT 1
`define BCL_ST_CLS_LSB 4
`define BCL_ST_LEN_LSB 8
`define BCL_ST_CYC_LSB 16

`define BCL_OP_JMP_ABS 8'hFC
`define BCL_OP_IND 8'h7D
`define BCL_OP_SPECIAL_PAGE_JUMP 8'hEE
`define BCL_OP_JSR_W 8'hF5
`define BCL_OP_JSR_A 8'hFD
`define BCL_OP_SPECIAL_PAGE_CALL 8'hEF
`define BCL_OP_LDC_IMM 8'hEB
`define BCL_OP_LDC_GEN 8'h7A
`define BCL_SUB_INDIRECT_JUMP_W 4'h2
`define BCL_SUB_INDIRECT_JUMP_A 4'h0
`define BCL_SUB_INDIRECT_CALL_W 4'h3
`define BCL_SUB_INDIRECT_CALL_A 4'h1

`define BCL_SRC_DATA_LOW 4'h0
`define BCL_SRC_DATA_HIGH 4'h1
`define BCL_SRC_ADDR_PAIR 4'h4
`define BCL_SRC_MEM_FIRST 4'h6
`define BCL_SRC_DSP8_FIRST 4'h8
`define BCL_SRC_DISPLACEMENT_20BIT_A0 4'hC
`define BCL_SRC_DISPLACEMENT_20BIT_A1 4'hD

`define BCL_LEN_ABS 3'd4
`define BCL_LEN_SPECIAL 3'd2
`define BCL_LEN_JSR_W 3'd3
`define BCL_LEN_LDC_IMM 3'd4
`define BCL_CYC_JMP_ABS 5'd4
`define BCL_CYC_INDIRECT_JUMP_W_REG 5'd7
`define BCL_CYC_INDIRECT_JUMP_W_MEM 5'd11
`define BCL_CYC_INDIRECT_JUMP_A_REG 5'd6
`define BCL_CYC_INDIRECT_JUMP_A_MEM 5'd10
`define BCL_CYC_SPECIAL_PAGE_JUMP 5'd9
`define BCL_CYC_JSR_W 5'd8
`define BCL_CYC_JSR_A 5'd9
`define BCL_CYC_INDIRECT_CALL_REG 5'd11
`define BCL_CYC_INDIRECT_CALL_MEM 5'd15
`define BCL_CYC_SPECIAL_PAGE_CALL 5'd13
`define BCL_CYC_LDC_IMM 5'd2
`define BCL_CYC_LDC_REG 5'd1
`define BCL_CYC_LDC_MEM 5'd3

`endif

// *** bcl_pkg.sv ***
// Types shared by the branch/call/load decoder modules
package bcl_pkg;
  typedef enum logic [3:0] {
    BCL_NONE, BCL_PEND, BCL_BAD, BCL_JMP_ABS, BCL_INDIRECT_JUMP_W, BCL_INDIRECT_JUMP_A, BCL_SPECIAL_PAGE_JUMP,
    BCL_JSR_W, BCL_JSR_A, BCL_INDIRECT_CALL_W, BCL_INDIRECT_CALL_A, BCL_SPECIAL_PAGE_CALL, BCL_LDC_IMM, BCL_LDC_GEN
  } bcl_cls_e;
  typedef enum logic [1:0] {BCL_PAIR_NONE, BCL_PAIR_DATA_LOW, BCL_PAIR_DATA_HIGH, BCL_PAIR_ADDR} bcl_pair_e;
  typedef enum logic {BCL_ST_FETCH, BCL_ST_EXEC} bcl_state_e;
endpackage : bcl_pkg

// *** bcl_timing.sv ***
// Byte length and cycle count of each decoded instruction form
`timescale 1ns/1ps
`include "bcl_regs.svh"
module bcl_timing (
  input wire bcl_pkg::bcl_cls_e cls,
  input wire logic [3:0] src,
  output logic [2:0] len,
  output logic [4:0] cyc
);
  // Length of a general operand form; wide means 20-bit displacement codes
  function automatic logic [2:0] src_len(input logic [3:0] code, input logic wide);
    if (code < `BCL_SRC_DSP8_FIRST) src_len = 3'd2;
    else if (code < `BCL_SRC_DISPLACEMENT_20BIT_A0) src_len = 3'd3;
    else if (wide && code <= `BCL_SRC_DISPLACEMENT_20BIT_A1) src_len = 3'd5;
    else src_len = 3'd4;
  endfunction : src_len

  function automatic logic is_mem(input logic [3:0] code);
    is_mem = (code >= `BCL_SRC_MEM_FIRST);
  endfunction : is_mem

  // Table lookup; pending and bad forms report a harmless length
  always_comb begin
    len = 3'd2;
    cyc = 5'd1;
    case (cls)
      bcl_pkg::BCL_JMP_ABS: begin len = `BCL_LEN_ABS; cyc = `BCL_CYC_JMP_ABS; end
      bcl_pkg::BCL_INDIRECT_JUMP_W: begin
        len = src_len(src, 1'b1);
        cyc = is_mem(src) ? `BCL_CYC_INDIRECT_JUMP_W_MEM : `BCL_CYC_INDIRECT_JUMP_W_REG;
      end
      bcl_pkg::BCL_INDIRECT_JUMP_A: begin
        len = src_len(src, 1'b1);
        cyc = is_mem(src) ? `BCL_CYC_INDIRECT_JUMP_A_MEM : `BCL_CYC_INDIRECT_JUMP_A_REG;
      end
      bcl_pkg::BCL_SPECIAL_PAGE_JUMP: begin len = `BCL_LEN_SPECIAL; cyc = `BCL_CYC_SPECIAL_PAGE_JUMP; end
      bcl_pkg::BCL_JSR_W: begin len = `BCL_LEN_JSR_W; cyc = `BCL_CYC_JSR_W; end
      bcl_pkg::BCL_JSR_A: begin len = `BCL_LEN_ABS; cyc = `BCL_CYC_JSR_A; end
      bcl_pkg::BCL_INDIRECT_CALL_W, bcl_pkg::BCL_INDIRECT_CALL_A: begin
        len = src_len(src, 1'b1);
        cyc = is_mem(src) ? `BCL_CYC_INDIRECT_CALL_MEM : `BCL_CYC_INDIRECT_CALL_REG;
      end
      bcl_pkg::BCL_SPECIAL_PAGE_CALL: begin len = `BCL_LEN_SPECIAL; cyc = `BCL_CYC_SPECIAL_PAGE_CALL; end
      bcl_pkg::BCL_LDC_IMM: begin len = `BCL_LEN_LDC_IMM; cyc = `BCL_CYC_LDC_IMM; end
      bcl_pkg::BCL_LDC_GEN: begin
        len = src_len(src, 1'b0);
        cyc = is_mem(src) ? `BCL_CYC_LDC_MEM : `BCL_CYC_LDC_REG;
      end
      default: begin len = 3'd2; cyc = 5'd1; end
    endcase
  end
endmodule : bcl_timing

// *** bcl_operand_sel.sv ***
// Register-pair, address-register and control-register selection from operand codes
`timescale 1ns/1ps
`include "bcl_regs.svh"
module bcl_operand_sel (
  input wire logic [3:0] src,
  input wire logic [2:0] dest,
  output bcl_pkg::bcl_pair_e pair_sel,
  output logic an_disp,
  output logic an_index,
  output logic [6:0] ctrl_sel
);
  // Pair codes of the 20-bit indirect forms; others have no pair
  always_comb begin
    case (src)
      `BCL_SRC_DATA_LOW: pair_sel = bcl_pkg::BCL_PAIR_DATA_LOW;
      `BCL_SRC_DATA_HIGH: pair_sel = bcl_pkg::BCL_PAIR_DATA_HIGH;
      `BCL_SRC_ADDR_PAIR: pair_sel = bcl_pkg::BCL_PAIR_ADDR;
      default: pair_sel = bcl_pkg::BCL_PAIR_NONE;
    endcase
  end

  // Displacement added to the first or second address register
  assign an_disp = (src == `BCL_SRC_DISPLACEMENT_20BIT_A0) || (src == `BCL_SRC_DISPLACEMENT_20BIT_A1);
  assign an_index = (src == `BCL_SRC_DISPLACEMENT_20BIT_A1);

  // One-hot select: bit 0 vector base low up to bit 6 frame base; code 000 selects none
  assign ctrl_sel = (dest == 3'h0) ? 7'h00 : 7'(7'h01 << (dest - 3'h1));
endmodule : bcl_operand_sel

// *** bcl_decoder.sv ***
// Branch, call and control-register load decoder with fetch-stream input and APB registers
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "bcl_regs.svh"
// Notes on behaviour
// - Absolute long jump: opcode plus 20-bit target, four bytes, four cycles.
// - 16-bit indirect jump: 7 cycles register, 11 memory; displacement form five bytes.
// - 20-bit indirect jump: 6 cycles pair operand, 10 memory; displacement form five bytes.
// - Special-page jump: 8-bit selector in byte two, two bytes, nine cycles.
// - Relative call target is first-byte address plus one plus displacement.
// - Relative call: opcode plus 16-bit displacement, three bytes, eight cycles.
// - Absolute long call: opcode plus 20-bit target, four bytes, nine cycles.
// - Indirect calls: 11 cycles register, 15 memory; displacement form five bytes.
// - Special-page call: 8-bit selector after opcode, two bytes, thirteen cycles.
// - Control load immediate: two-byte opcode, 3-bit destination, four bytes, two cycles.
// - Destination 001..111 select vector base low/high, flags, stacks, static, frame.
// - Control load general: 1 cycle register source, 3 memory, two to four bytes.
// - Pair codes 0000, 0001, 0100 select data low, data high, address pair.
// - Codes 1100 and 1101 select 20-bit displacement on first/second address register.
// - Unselectable codes are not issued; behaviour for them is left undefined.
module bcl_decoder (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_byte,
  output logic fetch_ready,
  output logic done,
  output logic [19:0] target_addr,
  output logic target_known,
  output logic [3:0] operand_code,
  output logic [19:0] operand_disp,
  output bcl_pkg::bcl_pair_e pair_sel,
  output logic an_disp,
  output logic an_index,
  output logic [6:0] ctrl_sel,
  output logic ctrl_wr,
  output logic [15:0] ctrl_data,
  output logic push_valid,
  output logic [19:0] push_addr
);
  localparam int MAX_LEN = 5;

  bcl_pkg::bcl_state_e state;
  bcl_pkg::bcl_cls_e cls;
  bcl_pkg::bcl_cls_e cls_now;
  bcl_pkg::bcl_pair_e next_pair;
  logic [7:0] ibuf [0:MAX_LEN-1];
  logic [7:0] cur [0:MAX_LEN-1];
  logic [2:0] got;
  logic [2:0] len_now;
  logic [4:0] cyc_now;
  logic [2:0] len;
  logic [4:0] cyc;
  logic [4:0] cnt;
  logic enable;
  logic bad_seen;
  logic [19:0] pc;
  logic [19:0] start_pc;
  logic accept;
  logic last;
  logic is_call;
  logic next_an_disp;
  logic next_an_index;
  logic [6:0] next_ctrl_sel;
  logic [19:0] next_target;
  logic next_known;
  logic [19:0] next_disp;
  logic [19:0] next_addr;
  logic apb_wr;

  // Class from the opcode byte, and the second byte where the opcode is shared
  function automatic bcl_pkg::bcl_cls_e decode_cls(input logic [7:0] op, input logic [7:0] b2, input logic have2);
    case (op)
      `BCL_OP_JMP_ABS: decode_cls = bcl_pkg::BCL_JMP_ABS;
      `BCL_OP_SPECIAL_PAGE_JUMP: decode_cls = bcl_pkg::BCL_SPECIAL_PAGE_JUMP;
      `BCL_OP_JSR_W: decode_cls = bcl_pkg::BCL_JSR_W;
      `BCL_OP_JSR_A: decode_cls = bcl_pkg::BCL_JSR_A;
      `BCL_OP_SPECIAL_PAGE_CALL: decode_cls = bcl_pkg::BCL_SPECIAL_PAGE_CALL;
      `BCL_OP_IND: begin
        if (!have2) decode_cls = bcl_pkg::BCL_PEND;
        else begin
          case (b2[7:4])
            `BCL_SUB_INDIRECT_JUMP_W: decode_cls = bcl_pkg::BCL_INDIRECT_JUMP_W;
            `BCL_SUB_INDIRECT_JUMP_A: decode_cls = bcl_pkg::BCL_INDIRECT_JUMP_A;
            `BCL_SUB_INDIRECT_CALL_W: decode_cls = bcl_pkg::BCL_INDIRECT_CALL_W;
            `BCL_SUB_INDIRECT_CALL_A: decode_cls = bcl_pkg::BCL_INDIRECT_CALL_A;
            default: decode_cls = bcl_pkg::BCL_BAD;
          endcase
        end
      end
      `BCL_OP_LDC_IMM: begin
        if (!have2) decode_cls = bcl_pkg::BCL_PEND;
        else decode_cls = (b2[7] == 1'b0 && b2[3:0] == 4'h0) ? bcl_pkg::BCL_LDC_IMM : bcl_pkg::BCL_BAD;
      end
      `BCL_OP_LDC_GEN: begin
        if (!have2) decode_cls = bcl_pkg::BCL_PEND;
        else decode_cls = b2[7] ? bcl_pkg::BCL_LDC_GEN : bcl_pkg::BCL_BAD;
      end
      default: decode_cls = bcl_pkg::BCL_BAD;
    endcase
  endfunction : decode_cls

  // Current byte merged into the held bytes so results are ready on the last fetch edge
  genvar gi;
  generate
    for (gi = 0; gi < MAX_LEN; gi++) begin : g_cur
      assign cur[gi] = (got == 3'(gi)) ? fetch_byte : ibuf[gi];
    end
  endgenerate

  assign cls_now = decode_cls(cur[0], cur[1], got != 3'd0);
  assign fetch_ready = enable && (state == bcl_pkg::BCL_ST_FETCH);
  assign accept = fetch_valid && fetch_ready;
  assign last = accept && (cls_now != bcl_pkg::BCL_PEND) && (cls_now != bcl_pkg::BCL_BAD) &&
                ((got + 3'd1) == len_now);
  assign done = (state == bcl_pkg::BCL_ST_EXEC) && (cnt == 5'd0);
  assign is_call = (cls_now == bcl_pkg::BCL_JSR_W) || (cls_now == bcl_pkg::BCL_JSR_A) ||
                   (cls_now == bcl_pkg::BCL_INDIRECT_CALL_W) || (cls_now == bcl_pkg::BCL_INDIRECT_CALL_A) ||
                   (cls_now == bcl_pkg::BCL_SPECIAL_PAGE_CALL);
  assign next_addr = start_pc + {17'h00000, len_now};

  bcl_timing u_timing (
    .cls(cls_now),
    .src(cur[1][3:0]),
    .len(len_now),
    .cyc(cyc_now)
  );

  bcl_operand_sel u_sel (
    .src(cur[1][3:0]),
    .dest(cur[1][6:4]),
    .pair_sel(next_pair),
    .an_disp(next_an_disp),
    .an_index(next_an_index),
    .ctrl_sel(next_ctrl_sel)
  );

  // Target of direct forms, and displacement bytes after the operand byte
  always_comb begin
    next_target = 20'h00000;
    next_known = 1'b0;
    next_disp = 20'h00000;
    case (cls_now)
      bcl_pkg::BCL_JMP_ABS, bcl_pkg::BCL_JSR_A: begin
        next_target = {cur[3][3:0], cur[2], cur[1]};
        next_known = 1'b1;
      end
      bcl_pkg::BCL_JSR_W: begin
        next_target = start_pc + 20'h00001 + {{4{cur[2][7]}}, cur[2], cur[1]};
        next_known = 1'b1;
      end
      bcl_pkg::BCL_SPECIAL_PAGE_JUMP, bcl_pkg::BCL_SPECIAL_PAGE_CALL: next_disp = {12'h000, cur[1]};
      bcl_pkg::BCL_INDIRECT_JUMP_W, bcl_pkg::BCL_INDIRECT_JUMP_A, bcl_pkg::BCL_INDIRECT_CALL_W, bcl_pkg::BCL_INDIRECT_CALL_A,
      bcl_pkg::BCL_LDC_GEN: begin
        // Only bytes inside the instruction length count
        if (len_now > 3'd2) next_disp[7:0] = cur[2];
        if (len_now > 3'd3) next_disp[15:8] = cur[3];
        if (len_now > 3'd4) next_disp[19:16] = cur[4][3:0];
      end
      default: next_disp = 20'h00000;
    endcase
  end

  // Byte collection and the fetch/execute sequence
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= bcl_pkg::BCL_ST_FETCH;
      got <= 3'd0;
      cnt <= 5'd0;
    end else begin
      case (state)
        bcl_pkg::BCL_ST_FETCH: begin
          if (accept && cls_now == bcl_pkg::BCL_BAD) begin
            got <= 3'd0; // Undefined encodings are dropped
          end else if (last) begin
            got <= 3'd0;
            cnt <= cyc_now - 5'd1;
            state <= bcl_pkg::BCL_ST_EXEC;
          end else if (accept) begin
            got <= got + 3'd1;
          end
        end
        bcl_pkg::BCL_ST_EXEC: begin
          if (cnt == 5'd0) state <= bcl_pkg::BCL_ST_FETCH;
          else cnt <= cnt - 5'd1;
        end
        default: state <= bcl_pkg::BCL_ST_FETCH;
      endcase
    end
  end

  // Instruction byte store
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < MAX_LEN; i++) ibuf[i] <= 8'h00;
    end else if (accept && got < 3'(MAX_LEN)) begin
      ibuf[got] <= fetch_byte;
    end
  end

  // Decoded results, captured on the last byte and held until the next one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cls <= bcl_pkg::BCL_NONE;
      len <= 3'd0;
      cyc <= 5'd0;
      target_addr <= 20'h00000;
      target_known <= 1'b0;
      operand_code <= 4'h0;
      operand_disp <= 20'h00000;
      pair_sel <= bcl_pkg::BCL_PAIR_NONE;
      an_disp <= 1'b0;
      an_index <= 1'b0;
      ctrl_sel <= 7'h00;
      ctrl_data <= 16'h0000;
    end else if (last) begin
      cls <= cls_now;
      len <= len_now;
      cyc <= cyc_now;
      target_addr <= next_target;
      target_known <= next_known;
      operand_code <= cur[1][3:0];
      operand_disp <= next_disp;
      // Pair meaning only applies to the 20-bit indirect forms
      pair_sel <= (cls_now == bcl_pkg::BCL_INDIRECT_JUMP_A || cls_now == bcl_pkg::BCL_INDIRECT_CALL_A) ?
                  next_pair : bcl_pkg::BCL_PAIR_NONE;
      an_disp <= next_an_disp && (cls_now != bcl_pkg::BCL_LDC_GEN);
      an_index <= next_an_index;
      ctrl_sel <= (cls_now == bcl_pkg::BCL_LDC_IMM || cls_now == bcl_pkg::BCL_LDC_GEN) ?
                  next_ctrl_sel : 7'h00;
      ctrl_data <= {cur[3], cur[2]};
    end
  end

  // Return address push on entry to execution; the control-register write of an immediate load at its end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      push_valid <= 1'b0;
      push_addr <= 20'h00000;
      ctrl_wr <= 1'b0;
    end else begin
      push_valid <= last && is_call;
      if (last && is_call) push_addr <= next_addr;
      // Immediate load strobes the write in its done cycle, once the data has settled
      ctrl_wr <= 1'b0;
      if (state == bcl_pkg::BCL_ST_EXEC && cnt == 5'd1 && cls == bcl_pkg::BCL_LDC_IMM) ctrl_wr <= 1'b1;
    end
  end

  // Program counter: start of the instruction being fetched; software may set it while idle
  assign apb_wr = psel && penable && pwrite;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc <= `BCL_PC_RESET;
      start_pc <= `BCL_PC_RESET;
    end else if (last) begin
      pc <= next_known ? next_target : next_addr;
      start_pc <= next_known ? next_target : next_addr;
    end else if (apb_wr && paddr == `BCL_OFF_PC && state == bcl_pkg::BCL_ST_FETCH && got == 3'd0) begin
      pc <= pwdata[19:0];
      start_pc <= pwdata[19:0];
    end
  end

  // Control register and sticky bad-encoding flag; a new bad byte wins over the clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable <= `BCL_CTRL_RESET;
      bad_seen <= 1'b0;
    end else begin
      if (apb_wr && paddr == `BCL_OFF_CTRL) enable <= pwdata[`BCL_CTRL_EN_BIT];
      if (accept && cls_now == bcl_pkg::BCL_BAD) bad_seen <= 1'b1;
      else if (apb_wr && paddr == `BCL_OFF_STATUS && pwdata[`BCL_ST_BAD_BIT]) bad_seen <= 1'b0;
    end
  end

  // APB read mux; unmapped addresses read zero with an error
  always_comb begin
    prdata = 32'h00000000;
    pslverr = 1'b0;
    case (paddr)
      `BCL_OFF_CTRL: prdata[`BCL_CTRL_EN_BIT] = enable;
      `BCL_OFF_PC: prdata[19:0] = pc;
      `BCL_OFF_STATUS: begin
        prdata[`BCL_ST_BUSY_BIT] = (state == bcl_pkg::BCL_ST_EXEC) || (got != 3'd0);
        prdata[`BCL_ST_BAD_BIT] = bad_seen;
        prdata[`BCL_ST_CLS_LSB +: 4] = cls;
        prdata[`BCL_ST_LEN_LSB +: 3] = len;
        prdata[`BCL_ST_CYC_LSB +: 5] = cyc;
      end
      `BCL_OFF_TARGET: prdata[20:0] = {target_known, target_addr};
      `BCL_OFF_OPERAND: prdata[23:0] = {operand_code, operand_disp};
      `BCL_OFF_RETADDR: prdata[19:0] = push_addr;
      default: pslverr = psel && penable;
    endcase
  end
  assign pready = 1'b1; // Every access completes in its first access cycle

  // Helper: exec cycles counted from one on the entry cycle
  logic [4:0] run_len;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) run_len <= 5'd0;
    else if (last) run_len <= 5'd1;
    else if (state == bcl_pkg::BCL_ST_EXEC) run_len <= run_len + 5'd1;
  end

  sequence seq_push;
    push_valid;
  endsequence
  sequence seq_call_end;
    run_len == 5'd1 ##[0:14] done;
  endsequence

  jmp_abs_cyc_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && cls == bcl_pkg::BCL_JMP_ABS |-> run_len == 5'd4 && len == 3'd4)
    else $error("absolute jump timing wrong");
  indirect_jump_w_cyc_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && cls == bcl_pkg::BCL_INDIRECT_JUMP_W |-> run_len == ((operand_code >= 4'h6) ? 5'd11 : 5'd7))
    else $error("16-bit indirect jump timing wrong");
  indirect_jump_a_cyc_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && cls == bcl_pkg::BCL_INDIRECT_JUMP_A |-> run_len == ((operand_code >= 4'h6) ? 5'd10 : 5'd6))
    else $error("20-bit indirect jump timing wrong");
  special_cyc_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && (cls == bcl_pkg::BCL_SPECIAL_PAGE_JUMP || cls == bcl_pkg::BCL_SPECIAL_PAGE_CALL) |->
    len == 3'd2 && run_len == ((cls == bcl_pkg::BCL_SPECIAL_PAGE_JUMP) ? 5'd9 : 5'd13))
    else $error("special page timing wrong");
  rel_target_a: assert property (@(posedge clk) disable iff (!reset_n)
    last && cls_now == bcl_pkg::BCL_JSR_W |=> target_addr == $past(start_pc) + 20'h00001 +
    {{4{$past(cur[2][7])}}, $past({cur[2], cur[1]})})
    else $error("relative call target wrong");
  call_cyc_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && (cls == bcl_pkg::BCL_JSR_W || cls == bcl_pkg::BCL_JSR_A) |->
    run_len == ((cls == bcl_pkg::BCL_JSR_W) ? 5'd8 : 5'd9))
    else $error("direct call timing wrong");
  indirect_call_cyc_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && (cls == bcl_pkg::BCL_INDIRECT_CALL_W || cls == bcl_pkg::BCL_INDIRECT_CALL_A) |->
    run_len == ((operand_code >= 4'h6) ? 5'd15 : 5'd11))
    else $error("indirect call timing wrong");
  ldc_imm_wr_a: assert property (@(posedge clk) disable iff (!reset_n)
    last && cls_now == bcl_pkg::BCL_LDC_IMM |=> !done ##1 (done && ctrl_wr) ##1 !ctrl_wr)
    else $error("immediate control load sequence wrong");
  ctrl_dest_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && cls == bcl_pkg::BCL_LDC_GEN && operand_disp == 20'h00000 && $past(state) == bcl_pkg::BCL_ST_FETCH
    |-> $onehot0(ctrl_sel))
    else $error("control destination not one-hot");
  ldc_gen_cyc_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && cls == bcl_pkg::BCL_LDC_GEN |-> run_len == ((operand_code >= 4'h6) ? 5'd3 : 5'd1))
    else $error("general control load timing wrong");
  pair_pick_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && (cls == bcl_pkg::BCL_INDIRECT_JUMP_A || cls == bcl_pkg::BCL_INDIRECT_CALL_A) && operand_code == 4'h4 |->
    pair_sel == bcl_pkg::BCL_PAIR_ADDR)
    else $error("address pair not selected");
  disp_pick_a: assert property (@(posedge clk) disable iff (!reset_n)
    done && (cls == bcl_pkg::BCL_INDIRECT_JUMP_W || cls == bcl_pkg::BCL_INDIRECT_JUMP_A) && operand_code == 4'hD |->
    an_disp && an_index && len == 3'd5)
    else $error("20-bit displacement selection wrong");
  call_push_a: assert property (@(posedge clk) disable iff (!reset_n)
    seq_push |-> seq_call_end)
    else $error("call push not followed by completion");
endmodule : bcl_decoder

// *** bcl_fetch_model.sv ***
// Program-memory model that feeds the decoder's fetch stream
`timescale 1ns/1ps
module bcl_fetch_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fetch_ready,
  output logic fetch_valid,
  output logic [7:0] fetch_byte
);
  // Only selectable operand codes are ever stored here
  logic [7:0] mem [0:255];
  int n = 0;
  int rd = 0;
  int nxt;
  logic slow = 1'b0;
  logic gap = 1'b0;
  // One byte per cycle, or every other cycle when slow, in program order; an offer is held until taken
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fetch_valid <= 1'b0;
      fetch_byte <= 8'h00;
    end else begin
      nxt = rd + int'(fetch_valid && fetch_ready);
      rd <= nxt;
      gap <= slow && !gap;
      if ((fetch_valid && !fetch_ready) || (nxt < n && !(slow && !gap))) begin
        fetch_valid <= 1'b1;
        fetch_byte <= mem[nxt];
      end else begin
        // Idle bus inverts, so stale data never looks fresh
        fetch_valid <= 1'b0;
        fetch_byte <= ~fetch_byte;
      end
    end
  end
endmodule : bcl_fetch_model

// *** test_bcl_decoder.sv ***
// Self-checking bench for the branch, call and control-load decoder
`timescale 1ns/1ps
`include "bcl_regs.svh"
module test_bcl_decoder;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_val;
  logic pready, pslverr, fetch_valid, fetch_ready, done, target_known;
  logic an_disp, an_index, ctrl_wr, push_valid, rd_err;
  logic [7:0] fetch_byte;
  logic [19:0] target_addr, operand_disp, push_addr, last_push;
  logic [3:0] operand_code;
  logic [3:0] pc [3] = '{4'h0, 4'h1, 4'h4};
  logic [6:0] ctrl_sel;
  logic [15:0] ctrl_data;
  bcl_pkg::bcl_pair_e pair_sel;
  int num_errors = 0, checked = 0, cycles = 0, pushes = 0, writes = 0;
  always #4 clk = ~clk;
  bcl_decoder i_bcl_decoder (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .fetch_valid, .fetch_byte, .fetch_ready, .done, .target_addr, .target_known, .operand_code,
    .operand_disp, .pair_sel, .an_disp, .an_index, .ctrl_sel, .ctrl_wr, .ctrl_data, .push_valid, .push_addr);
  bcl_fetch_model i_bcl_fetch_model (.clk, .reset_n, .fetch_ready, .fetch_valid, .fetch_byte);
  // One-cycle pulses are caught mid-cycle
  always @(negedge clk) begin
    if (push_valid === 1'b1) begin
      pushes++;
      last_push = push_addr;
    end
    if (ctrl_wr === 1'b1) writes++;
  end
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Feed one instruction, count execution cycles, then read its length and count back
  task automatic t(input logic [39:0] c, input logic [2:0] nb, input logic [4:0] ny);
    int seen;
    seen = 0;
    for (int i = 0; i < nb; i++) i_bcl_fetch_model.mem[i_bcl_fetch_model.n + i] <= c[8*i +: 8];
    i_bcl_fetch_model.n <= i_bcl_fetch_model.n + nb;
    do begin
      @(negedge clk);
      if (fetch_ready === 1'b0) seen++;
    end while (done !== 1'b1);
    chk("cycles", 32'(ny), 32'(seen));
    apb(1'b0, `BCL_OFF_STATUS, 32'h0);
    chk("status bytes", 32'(nb), 32'(rd_val[10:8]));
    chk("status cycles", 32'(ny), 32'(rd_val[20:16]));
    chk("busy", 32'h0, 32'(rd_val[0]));
  endtask : t
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, `BCL_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd_val);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, rd_err});
    apb(1'b1, `BCL_OFF_CTRL, 32'h0);
    @(negedge clk);
    chk("disabled", 32'h0, 32'(fetch_ready));
    apb(1'b1, `BCL_OFF_CTRL, 32'h1);
    t(40'h00123456FC, 3'd4, 5'd4);
    chk("target", 32'h123456, {11'h0, target_known, target_addr});
    t(40'h207D, 3'd2, 5'd7);
    t(40'h267D, 3'd2, 5'd11);
    t(40'h0ABCDE2C7D, 3'd5, 5'd11);
    chk("disp a0", 32'h2ABCDE, {10'h0, an_disp, an_index, operand_disp});
    foreach (pc[i]) begin
      t({28'h0, pc[i], 8'h7D}, 3'd2, 5'd6);
      chk("pair", 32'(i + 1), 32'(pair_sel));
    end
    t(40'h077D, 3'd2, 5'd10);
    t(40'h0123450D7D, 3'd5, 5'd10);
    chk("disp a1", 32'h312345, {10'h0, an_disp, an_index, operand_disp});
    chk("code", 32'hD, 32'(operand_code));
    t(40'h5AEE, 3'd2, 5'd9);
    chk("selector", 32'h5A, 32'(operand_disp));
    apb(1'b1, `BCL_OFF_PC, 32'h01000);
    t(40'h0010F5, 3'd3, 5'd8);
    chk("rel target", 32'h101011, {11'h0, target_known, target_addr});
    chk("rel push", 32'h01003, 32'(last_push));
    t(40'h05432121FD & 40'h00FFFFFFFF, 3'd4, 5'd9);
    chk("abs push", 32'h01015, 32'(last_push));
    apb(1'b0, `BCL_OFF_PC, 32'h0);
    chk("pc", 32'h32121, rd_val);
    apb(1'b0, `BCL_OFF_RETADDR, 32'h0);
    chk("ret addr", 32'h01015, rd_val);
    t(40'h307D, 3'd2, 5'd11);
    t(40'h367D, 3'd2, 5'd15);
    t(40'h0ABCDE3C7D, 3'd5, 5'd15);
    t(40'h107D, 3'd2, 5'd11);
    t(40'h34121E7D, 3'd4, 5'd15);
    t(40'h03EF, 3'd2, 5'd13);
    chk("pushes", 32'd8, 32'(pushes));
    for (int j = 1; j < 8; j++) begin
      t({8'h00, 16'hA5C0 + 16'(j), 1'b0, 3'(j), 12'h0EB}, 3'd4, 5'd2);
      chk("ctrl sel", 32'(1 << (j - 1)), 32'(ctrl_sel));
      chk("ctrl data", 32'hA5C0 + j, 32'(ctrl_data));
    end
    chk("ctrl writes", 32'd7, 32'(writes));
    i_bcl_fetch_model.slow = 1'b1;
    t(40'h907A, 3'd2, 5'd1);
    t(40'h967A, 3'd2, 5'd3);
    t(40'h55987A, 3'd3, 5'd3);
    t(40'h12349F7A, 3'd4, 5'd3);
    wrap_up();
  end
endmodule : test_bcl_decoder
